// File: timekeeping_pkg.sv
// shared constants of the precision time counter and pulse output block
// assumes: register accesses arrive already decoded from the serial port
package timekeeping_pkg;

	// ----------------------------------------------------------------
	// register offsets (word index on the serial register port)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SECOND_ROLLOVER_COMPARE = 8'h81;
	localparam logic [7:0] ADDR_SECONDS_COUNTER_LOAD = 8'h82;
	localparam logic [7:0] ADDR_NANOSECONDS_COUNTER_LOAD = 8'h83;
	localparam logic [7:0] ADDR_TIMEKEEPING_CONFIG = 8'h84;
	localparam logic [7:0] ADDR_PULSE_OUTPUT_HIGH_PERIOD = 8'h85;
	localparam logic [7:0] ADDR_PULSE_OUTPUT_LOW_PERIOD = 8'h86;
	localparam logic [7:0] ADDR_PULSE_OUTPUT_START_TIME = 8'h88;

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_CLEAR_BIT = 1;
	localparam int CFG_IDLE_LEVEL_BIT = 2;
	localparam int CFG_HALT_BIT = 3;
	localparam int CFG_CAPT_FREE_BIT = 4;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [31:0] ROLLOVER_RESET = 32'h3B9ACA00;
	localparam logic [31:0] NS_STEP = 32'h0000_0010;
	localparam logic [31:0] MIN_START_TIME = 32'h0000_0010;
	localparam int SYS_CLK_MHZ = 200;
	localparam int COUNT_CLK_MHZ = 120;
	// narrow timestamp: low seconds bits above nanoseconds
	localparam int NARROW_NS_BITS = 30;
	localparam int NARROW_SEC_BITS = 2;

	typedef enum logic [3:0] {
		PULSE_IDLE = 4'b0001,
		PULSE_ARMED = 4'b0010,
		PULSE_HIGH = 4'b0100,
		PULSE_LOW = 4'b1000
	} pulse_state_t;

endpackage : timekeeping_pkg

// File: rate_tick.sv
// fractional divider giving a one-cycle enable at num/den of clk rate
// assumes: num below den, both small; one clock domain
`timescale 1ns/1ps
`default_nettype none

module rate_tick #(
	parameter int NUM = 3,
	parameter int DEN = 5
) (
	input wire logic clk, // system clock
	input wire logic reset_n, // async reset, active low
	output logic tick // one-cycle enable pulse
);

	localparam int AW = $clog2(DEN) + 1;
	localparam logic [AW-1:0] NUM_W = AW'(NUM);
	localparam logic [AW-1:0] DEN_W = AW'(DEN);

	logic [AW-1:0] acc_q;
	logic [AW-1:0] sum;

	assign sum = acc_q + NUM_W;

	// ----------------------------------------------------------------
	// phase accumulator; evenly spread ticks, no long-term drift
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= '0;
			tick <= 1'b0;
		end else if (sum >= DEN_W) begin
			acc_q <= sum - DEN_W;
			tick <= 1'b1;
		end else begin
			acc_q <= sum;
			tick <= 1'b0;
		end
	end

endmodule : rate_tick

`default_nettype wire

// File: precision_time_counter.sv
// precision time counters, receive timestamp capture and pulse output
// assumes: register port driven by same-clock serial decoder logic;
// frame-start strobe comes from the same clock domain
//
// Contract
// - one-second compare register, 32 bits, resets to 0x3B9ACA00
// - writing seconds register loads the seconds counter
// - nanoseconds and free-run counters step by sixteen on a 120 MHz rate
// - capture format: wide select, else free-run bit picks free or narrow
// - halt bit stops pulse output, restores idle level, self-clears
// - after halt, pulse resumes only on a new start-time write
// - idle-level bit sets pin level; setting it drives pin high two cycles after the write
// - idle-level writes ignored once pulse output has started
// - clear bit zeros all counters and self-clears
// - enable bit runs counters and captures a stamp per frame
// - with enable low, counters freeze without clearing
// - start-time write of at least sixteen starts the pulse output
`timescale 1ns/1ps
`default_nettype none

module precision_time_counter (
	input wire logic clk, // 200 MHz system clock
	input wire logic reset_n, // async reset, active low
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [31:0] reg_wdata, // write data
	output logic [31:0] reg_rdata, // read data, valid with reg_rvalid
	output logic reg_rvalid, // read answer pulse
	input wire logic wide_timestamp_select, // 64-bit stamp format select
	input wire logic rx_frame_start, // frame received pulse
	output logic [63:0] rx_timestamp, // captured stamp
	output logic rx_timestamp_valid, // capture pulse
	output logic [31:0] seconds_now, // live seconds counter
	output logic [31:0] nanoseconds_now, // live nanoseconds counter
	output logic pulse_output_pin // timer output pin
);

	logic count_tick;
	logic [31:0] rollover_q;
	logic [31:0] sec_q;
	logic [31:0] ns_q;
	logic [31:0] free_q;
	logic enable_q;
	logic capt_free_q;
	logic idle_level_q;
	logic [31:0] high_period_q;
	logic [31:0] low_period_q;
	logic [31:0] start_time_q;
	logic [31:0] phase_ns_q;
	timekeeping_pkg::pulse_state_t state_q;
	logic pin_q;

	logic wr_rollover;
	logic wr_sec;
	logic wr_ns;
	logic wr_cfg;
	logic wr_high;
	logic wr_low;
	logic wr_start;
	logic clear_req;
	logic halt_req;
	logic step;
	logic [31:0] ns_next;

	assign wr_rollover = reg_wr &&
		reg_addr == timekeeping_pkg::ADDR_SECOND_ROLLOVER_COMPARE;
	assign wr_sec = reg_wr &&
		reg_addr == timekeeping_pkg::ADDR_SECONDS_COUNTER_LOAD;
	assign wr_ns = reg_wr &&
		reg_addr == timekeeping_pkg::ADDR_NANOSECONDS_COUNTER_LOAD;
	assign wr_cfg = reg_wr &&
		reg_addr == timekeeping_pkg::ADDR_TIMEKEEPING_CONFIG;
	assign wr_high = reg_wr &&
		reg_addr == timekeeping_pkg::ADDR_PULSE_OUTPUT_HIGH_PERIOD;
	assign wr_low = reg_wr &&
		reg_addr == timekeeping_pkg::ADDR_PULSE_OUTPUT_LOW_PERIOD;
	assign wr_start = reg_wr &&
		reg_addr == timekeeping_pkg::ADDR_PULSE_OUTPUT_START_TIME;
	// self-clearing command bits: never stored, so they read back zero
	assign clear_req = wr_cfg && reg_wdata[timekeeping_pkg::CFG_CLEAR_BIT];
	assign halt_req = wr_cfg && reg_wdata[timekeeping_pkg::CFG_HALT_BIT];

	// ----------------------------------------------------------------
	// counting rate
	// ----------------------------------------------------------------
	// 120 MHz rate
	rate_tick #(
		.NUM(timekeeping_pkg::COUNT_CLK_MHZ),
		.DEN(timekeeping_pkg::SYS_CLK_MHZ)
	) u_rate_tick (
		.clk(clk),
		.reset_n(reset_n),
		.tick(count_tick)
	);

	assign step = count_tick && enable_q;
	assign ns_next = ns_q + timekeeping_pkg::NS_STEP;

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// rollover compare
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rollover_q <= timekeeping_pkg::ROLLOVER_RESET;
		end else if (wr_rollover) begin
			rollover_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_q <= 1'b0;
			capt_free_q <= 1'b0;
			high_period_q <= '0;
			low_period_q <= '0;
			start_time_q <= '0;
		end else begin
			if (wr_cfg) begin
				enable_q <= reg_wdata[timekeeping_pkg::CFG_ENABLE_BIT];
				capt_free_q <= reg_wdata[timekeeping_pkg::CFG_CAPT_FREE_BIT];
			end
			if (wr_high) begin
				high_period_q <= reg_wdata;
			end
			if (wr_low) begin
				low_period_q <= reg_wdata;
			end
			if (wr_start) begin
				start_time_q <= reg_wdata;
			end
		end
	end

	// idle level frozen once output started
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_level_q <= 1'b0;
		end else if (wr_cfg && state_q == timekeeping_pkg::PULSE_IDLE) begin
			idle_level_q <= reg_wdata[timekeeping_pkg::CFG_IDLE_LEVEL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// time counters
	// ----------------------------------------------------------------
	// clear beats load beats counting in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_q <= '0;
			ns_q <= '0;
			free_q <= '0;
		end else if (clear_req) begin
			sec_q <= '0;
			ns_q <= '0;
			free_q <= '0;
		end else begin
			if (step) begin
				free_q <= free_q + timekeeping_pkg::NS_STEP;
			end
			if (wr_sec) begin
				sec_q <= reg_wdata;
			end else if (step && ns_next >= rollover_q) begin
				sec_q <= sec_q + 32'h0000_0001;
			end
			// load taken as written, host keeps it aligned
			if (wr_ns) begin
				ns_q <= reg_wdata;
			end else if (step) begin
				ns_q <= (ns_next >= rollover_q) ? '0 : ns_next;
			end
		end
	end

	assign seconds_now = sec_q;
	assign nanoseconds_now = ns_q;

	// ----------------------------------------------------------------
	// receive timestamp capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_timestamp <= '0;
			rx_timestamp_valid <= 1'b0;
		end else begin
			rx_timestamp_valid <= rx_frame_start && enable_q;
			if (rx_frame_start && enable_q) begin
				if (wide_timestamp_select) begin
					rx_timestamp <= {sec_q, ns_q};
				end else if (capt_free_q) begin
					rx_timestamp <= {32'h0000_0000, free_q};
				end else begin
					rx_timestamp <= {32'h0000_0000,
						sec_q[timekeeping_pkg::NARROW_SEC_BITS-1:0],
						ns_q[timekeeping_pkg::NARROW_NS_BITS-1:0]};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pulse output sequencer
	// ----------------------------------------------------------------
	// periods are counted in nanoseconds on the counting rate, so a
	// frozen time base also freezes the pulse output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= timekeeping_pkg::PULSE_IDLE;
			phase_ns_q <= '0;
		end else if (halt_req) begin
			state_q <= timekeeping_pkg::PULSE_IDLE;
			phase_ns_q <= '0;
		end else if (wr_start && reg_wdata >= timekeeping_pkg::MIN_START_TIME) begin
			state_q <= timekeeping_pkg::PULSE_ARMED;
			phase_ns_q <= '0;
		end else if (step) begin
			case (state_q)
				timekeeping_pkg::PULSE_IDLE: begin
					phase_ns_q <= '0;
				end
				timekeeping_pkg::PULSE_ARMED: begin
					// start instant matched on the step grid
					if (ns_q == start_time_q) begin
						state_q <= timekeeping_pkg::PULSE_HIGH;
						phase_ns_q <= '0;
					end
				end
				timekeeping_pkg::PULSE_HIGH: begin
					if (phase_ns_q + timekeeping_pkg::NS_STEP >= high_period_q) begin
						state_q <= timekeeping_pkg::PULSE_LOW;
						phase_ns_q <= '0;
					end else begin
						phase_ns_q <= phase_ns_q + timekeeping_pkg::NS_STEP;
					end
				end
				timekeeping_pkg::PULSE_LOW: begin
					if (phase_ns_q + timekeeping_pkg::NS_STEP >= low_period_q) begin
						state_q <= timekeeping_pkg::PULSE_HIGH;
						phase_ns_q <= '0;
					end else begin
						phase_ns_q <= phase_ns_q + timekeeping_pkg::NS_STEP;
					end
				end
				default: begin
					state_q <= timekeeping_pkg::PULSE_IDLE;
					phase_ns_q <= '0;
				end
			endcase
		end
	end

	// pin takes the stored idle level one cycle later, its inverse in the high state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_q <= 1'b0;
		end else if (state_q == timekeeping_pkg::PULSE_HIGH) begin
			pin_q <= ~idle_level_q;
		end else begin
			pin_q <= idle_level_q;
		end
	end

	assign pulse_output_pin = pin_q;

	// ----------------------------------------------------------------
	// register read-back
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					timekeeping_pkg::ADDR_SECOND_ROLLOVER_COMPARE:
						reg_rdata <= rollover_q;
					timekeeping_pkg::ADDR_SECONDS_COUNTER_LOAD:
						reg_rdata <= sec_q;
					timekeeping_pkg::ADDR_NANOSECONDS_COUNTER_LOAD:
						reg_rdata <= ns_q;
					timekeeping_pkg::ADDR_TIMEKEEPING_CONFIG: begin
						reg_rdata <= '0;
						reg_rdata[timekeeping_pkg::CFG_ENABLE_BIT] <= enable_q;
						reg_rdata[timekeeping_pkg::CFG_IDLE_LEVEL_BIT] <= idle_level_q;
						reg_rdata[timekeeping_pkg::CFG_CAPT_FREE_BIT] <= capt_free_q;
					end
					timekeeping_pkg::ADDR_PULSE_OUTPUT_HIGH_PERIOD:
						reg_rdata <= high_period_q;
					timekeeping_pkg::ADDR_PULSE_OUTPUT_LOW_PERIOD:
						reg_rdata <= low_period_q;
					timekeeping_pkg::ADDR_PULSE_OUTPUT_START_TIME:
						reg_rdata <= start_time_q;
					default:
						reg_rdata <= '0;
				endcase
			end
		end
	end

endmodule : precision_time_counter

`default_nettype wire

// File: ptc_monitor.sv
// port checker for the precision time counter and pulse output
// assumes: bound into precision_time_counter by the bench top
`timescale 1ns/1ps
`default_nettype none
module ptc_monitor (
	input wire logic clk, // clock
	input wire logic reset_n, // reset, active low
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_addr, // offset
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_rvalid, // read answer
	input wire logic wide_timestamp_select, // wide stamp format
	input wire logic rx_frame_start, // frame pulse
	input wire logic [63:0] rx_timestamp, // stamp
	input wire logic rx_timestamp_valid, // stamp pulse
	input wire logic [31:0] seconds_now, // seconds
	input wire logic [31:0] nanoseconds_now, // nanoseconds
	input wire logic pulse_output_pin // pulse pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic cfg_wr;
	assign cfg_wr = reg_wr && reg_addr == 8'h84;
	property p_read_answer;
		reg_rvalid == $past(reg_rd);
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read answer not one cycle after request");
	property p_sec_load;
		reg_wr && reg_addr == 8'h82 |=> seconds_now == $past(reg_wdata);
	endproperty
	a_sec_load: assert property (p_sec_load)
		else $error("seconds not loaded");
	property p_ns_step;
		$changed(nanoseconds_now) && !$past(reg_wr) |->
			nanoseconds_now == $past(nanoseconds_now) + 32'h10 ||
			nanoseconds_now == 32'h0;
	endproperty
	a_ns_step: assert property (p_ns_step)
		else $error("nanoseconds step not sixteen");
	property p_wide_stamp;
		rx_timestamp_valid && $past(wide_timestamp_select) |->
			rx_timestamp == {$past(seconds_now), $past(nanoseconds_now)};
	endproperty
	a_wide_stamp: assert property (p_wide_stamp)
		else $error("wide stamp wrong");
	property p_halt_still;
		cfg_wr && reg_wdata[3] |=> ##2 $stable(pulse_output_pin) [*6];
	endproperty
	a_halt_still: assert property (p_halt_still)
		else $error("pin moves after halt");
	property p_clear;
		cfg_wr && reg_wdata[1] |=> seconds_now == 32'h0 && nanoseconds_now == 32'h0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("counters not cleared");
	property p_capture_cause;
		rx_timestamp_valid |-> $past(rx_frame_start);
	endproperty
	a_capture_cause: assert property (p_capture_cause)
		else $error("stamp without frame");
	property p_sec_wrap;
		$changed(seconds_now) && !$past(reg_wr) |->
			seconds_now == $past(seconds_now) + 32'h1 && nanoseconds_now == 32'h0;
	endproperty
	a_sec_wrap: assert property (p_sec_wrap)
		else $error("seconds advance without wrap");
	c_capture: cover property (rx_timestamp_valid);
	c_pulse: cover property ($fell(pulse_output_pin));
	c_wrap: cover property ($changed(seconds_now) && !$past(reg_wr));
endmodule : ptc_monitor
`default_nettype wire

// File: host_model.sv
// host side of the register port: one write or read at a time
// assumes: same clock as the design, tasks called from the bench
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk, // clock
	input wire logic [31:0] reg_rdata, // read data
	input wire logic reg_rvalid, // read answer
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	output logic [7:0] reg_addr, // offset
	output logic [31:0] reg_wdata // write data
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		v = d;
		if (a inside {8'h83, 8'h85, 8'h86}) v[3:0] = 4'h0;
		if (a inside {8'h85, 8'h86} && v < 32'h10) v = 32'h10;
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		// released data shows the inverse, not a stale copy
		reg_wdata <= ~v;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rvalid ? reg_rdata : 32'hX;
	endtask : rd
endmodule : host_model
`default_nettype wire

// File: precision_time_counter_and_timer_output_tb.sv
// self-checking bench for precision_time_counter
// assumes: host_model drives the register port, checker bound below
`timescale 1ns/1ps
`default_nettype none
module precision_time_counter_and_timer_output_tb;
	logic clk, reset_n, reg_wr, reg_rd, reg_rvalid, wide_timestamp_select;
	logic rx_frame_start, rx_timestamp_valid, pulse_output_pin;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seconds_now, nanoseconds_now, v, n0, n1;
	logic [63:0] rx_timestamp, exp_ts;
	logic [31:0] shadow[int];
	int miscompares, checks_done;
	precision_time_counter precision_time_counter_inst (.clk, .reset_n,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
		.wide_timestamp_select, .rx_frame_start, .rx_timestamp,
		.rx_timestamp_valid, .seconds_now, .nanoseconds_now, .pulse_output_pin);
	host_model host_model_inst (.clk, .reg_rdata, .reg_rvalid, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata);
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		host_model_inst.wr(a, d);
		shadow[a] = (a == 8'h84) ? d & 32'h15 : d;
	endtask : put
	task automatic get(input logic [7:0] a);
		host_model_inst.rd(a, v);
		chk("register", shadow.exists(a) ? shadow[a] : 32'h0, v);
	endtask : get
	task automatic wait_pin(input logic l, output logic [31:0] n);
		for (int i = 0; i < 400 && pulse_output_pin !== l; i++) @(posedge clk) #1;
		chk("pin", l, pulse_output_pin);
		n = nanoseconds_now;
	endtask : wait_pin
	task automatic cap(input logic w, input logic [31:0] cfg, input logic en);
		put(8'h84, cfg);
		@(posedge clk);
		wide_timestamp_select <= w;
		rx_frame_start <= 1'b1;
		#1;
		exp_ts = w ? {seconds_now, nanoseconds_now} : cfg[4] ?
			{32'h0, nanoseconds_now} : {32'h0, seconds_now[1:0], nanoseconds_now[29:0]};
		@(posedge clk);
		rx_frame_start <= 1'b0;
		#1;
		chk("stamp valid", en, rx_timestamp_valid);
		if (en) chk("stamp", exp_ts, rx_timestamp);
	endtask : cap
	task automatic results();
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// whole run is under a thousand cycles
	initial begin
		#50000;
		miscompares++;
		results();
	end
	initial begin
		reset_n = 1'b0;
		wide_timestamp_select = 1'b0;
		rx_frame_start = 1'b0;
		miscompares = 0;
		checks_done = 0;
		shadow[8'h81] = 32'h3B9ACA00;
		void'($urandom(32'h65949D1F));
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		for (int a = 8'h81; a <= 8'h88; a++) get(a[7:0]);
		put(8'h84, $urandom & 32'h15);
		get(8'h84);
		put(8'h84, 32'h2);
		get(8'h82);
		get(8'h83);
		for (int a = 8'h81; a <= 8'h86; a++)
			if (a != 8'h84) put(a[7:0], $urandom & 32'h0FFFFFF0 | 32'h10);
		for (int a = 8'h81; a <= 8'h86; a++) get(a[7:0]);
		repeat (30) @(posedge clk);
		get(8'h82);
		get(8'h83);
		put(8'h81, 32'h3B9ACA00);
		put(8'h84, 32'h2);
		put(8'h84, 32'h1);
		repeat (100) @(posedge clk);
		put(8'h84, 32'h0);
		repeat (2) @(posedge clk);
		chk("rate", 1'b1, nanoseconds_now inside {[32'h3B0:32'h400]});
		chk("grid", 4'h0, nanoseconds_now[3:0]);
		n0 = nanoseconds_now;
		repeat (20) @(posedge clk);
		chk("frozen", n0, nanoseconds_now);
		put(8'h81, 32'h40);
		put(8'h84, 32'h2);
		put(8'h84, 32'h1);
		repeat (200) @(posedge clk);
		put(8'h84, 32'h0);
		repeat (2) @(posedge clk);
		chk("wrap", 1'b1, seconds_now inside {[32'h1D:32'h1F]});
		chk("wrap ns", 1'b1, nanoseconds_now < 32'h40);
		put(8'h81, 32'h3B9ACA00);
		put(8'h84, 32'h2);
		cap(1'b1, 32'h1, 1'b1);
		cap(1'b0, 32'h11, 1'b1);
		cap(1'b0, 32'h1, 1'b1);
		cap(1'b1, 32'h0, 1'b0);
		put(8'h84, 32'h2);
		put(8'h85, 32'h20);
		put(8'h86, 32'h30);
		put(8'h84, 32'h4);
		repeat (2) @(posedge clk);
		#1 chk("idle level", 1'b1, pulse_output_pin);
		put(8'h88, 32'h40);
		put(8'h84, 32'h5);
		wait_pin(1'b0, n0);
		wait_pin(1'b1, n1);
		chk("high", 1'b1, (n1 - n0) inside {32'h10, 32'h20, 32'h30});
		wait_pin(1'b0, n0);
		chk("low", 1'b1, (n0 - n1) inside {32'h20, 32'h30, 32'h40});
		put(8'h84, 32'h1);
		put(8'h84, 32'h9);
		repeat (3) @(posedge clk);
		#1 chk("halted", 1'b1, pulse_output_pin);
		repeat (60) @(posedge clk);
		chk("stays", 1'b1, pulse_output_pin);
		// start of zero refused even when time reads zero
		put(8'h84, 32'h4);
		put(8'h84, 32'h6);
		put(8'h88, 32'h0);
		put(8'h84, 32'h5);
		repeat (60) @(posedge clk);
		chk("small start", 1'b1, pulse_output_pin);
		put(8'h88, nanoseconds_now + 32'h100);
		wait_pin(1'b0, n0);
		put(8'h84, 32'h9);
		repeat (10) @(posedge clk);
		#1 chk("halted again", 1'b1, pulse_output_pin);
		results();
	end
endmodule : precision_time_counter_and_timer_output_tb
bind precision_time_counter ptc_monitor ptc_monitor_inst (.clk, .reset_n,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid,
	.wide_timestamp_select, .rx_frame_start, .rx_timestamp,
	.rx_timestamp_valid, .seconds_now, .nanoseconds_now, .pulse_output_pin);
`default_nettype wire
